/* hw/msc_pkg.sv */
// Purpose: shared constants for the miscellaneous system control unit
// Assumes: 32-bit APB register access, one aligned word per register
// Notes:   all offsets are byte addresses
package msc_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_CONFIG    = 12'h000;
  localparam logic [11:0] OFF_FLASH     = 12'h004;
  localparam logic [11:0] OFF_CORE      = 12'h008;
  localparam logic [11:0] OFF_ARB       = 12'h00c;
  localparam logic [11:0] OFF_FADDR     = 12'h010;
  localparam logic [11:0] OFF_FATTR     = 12'h014;
  localparam logic [11:0] OFF_FDATA     = 12'h018;
  localparam logic [11:0] OFF_FCTRL     = 12'h01c;
  localparam logic [11:0] OFF_FSTAT     = 12'h020;
  // config register fields
  localparam int CFG_SLV_LSB   = 0;
  localparam int CFG_MST_LSB   = 16;
  localparam int CFG_WIDE_BIT  = 24;
  // flash control fields
  localparam int FL_CLEAR_BIT  = 0;
  localparam int FL_NODATA_BIT = 1;
  localparam int FL_NOINST_BIT = 2;
  localparam int FL_NOCACHE_BIT= 3;
  localparam int FL_NODSPEC_BIT= 4;
  localparam int FL_NOSPEC_BIT = 5;
  localparam int FL_NOSTALL_BIT= 6;
  localparam logic [5:0] FL_RESET = 6'h00;
  // core feature fields
  localparam int CO_NOEXT_BIT  = 0;
  localparam int CO_NOREV_BIT  = 1;
  localparam int CO_NOSHAD_BIT = 2;
  localparam int CO_NOBUF_BIT  = 3;
  localparam logic [3:0] CO_RESET = 4'h0;
  // arbitration and fault control fields
  localparam int ARB_RR_BIT    = 0;
  localparam int FC_IRQ_EN_BIT = 0;
  // fault attribute fields
  localparam int AT_TYPE_BIT   = 0;
  localparam int AT_BUF_BIT    = 2;
  localparam int AT_SIZE_LSB   = 4;
  localparam int AT_DIR_BIT    = 7;
  localparam int AT_LOC_LSB    = 8;
  // fault status fields
  localparam int ST_INT_BIT    = 0;
  localparam int ST_LOST_BIT   = 1;
  typedef enum logic [1:0] {SZ_8 = 2'h0, SZ_16 = 2'h1, SZ_32 = 2'h2} msc_size_t;
  typedef enum logic [1:0] {LOC_INST = 2'h0, LOC_OPA = 2'h1, LOC_OPB = 2'h2} msc_loc_t;
  typedef enum logic {ARB_FIXED_CORE = 1'b0, ARB_ROUND_ROBIN = 1'b1} msc_arb_t;
endpackage

/* hw/msc_top.sv */
// Purpose: miscellaneous system control unit with APB register access
// Assumes: fault capture inputs come from logic on the same clock
// Notes:   flash stall policy is driven out as a level to the flash controller
//
// What this block does
// - read-only bit tells whether the datapath is 32 or 64 bits wide
// - read-only bitmap shows which crossbar slave ports have a slave
// - read-only bitmap shows which crossbar master ports have a master
// - software flush request gives a cache-clear pulse of exactly one cycle
// - control bit set stops flash data caching
// - control bit set stops flash instruction caching
// - control bit set disables the whole flash cache
// - control bit set disables speculative data fetches
// - control bit set disables all flash speculation
// - control bit set disables extended-core-only instructions
// - control bit set disables bit-reverse addressing
// - control bit set enables only base-core shadow registers
// - control bit set disables the longword instruction buffer
// - stall off: flash access during a command ends in bus error
// - stall on: flash access waits for the command, then proceeds
// - a setting selects DMA priority against the core in the crossbar
// - priority is fixed core-over-DMA or equal round-robin
// - address of the latest faulted core access is captured for software
// - attributes of the latest faulted access are captured
// - attributes give type, bufferable, size 8/16/32 and direction
// - the bus that carried the latest fault is recorded
// - location tells instruction bus, operand bus a or operand bus b
// - write data of the latest faulted data write is captured
// - with enable set, each faulted cycle raises the error interrupt
// - interrupt and data-lost flags are read and cleared one by one
// - a fault while the earlier one is uncleared sets data-lost
`timescale 1ns/100ps
module msc_top #(
  parameter int          SLV_PORTS  = 8,
  parameter int          MST_PORTS  = 8,
  parameter logic [15:0] SLV_MAP    = 16'h00ff,
  parameter logic [15:0] MST_MAP    = 16'h000f,
  parameter logic        WIDE_PATH  = 1'b0
) (
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // flash controller controls
  output logic             FLASH_CACHE_CLEAR_O,
  output logic             FLASH_NO_DATA_CACHE_O,
  output logic             FLASH_NO_INST_CACHE_O,
  output logic             FLASH_CACHE_OFF_O,
  output logic             FLASH_NO_DATA_SPEC_O,
  output logic             FLASH_NO_SPEC_O,
  output logic             FLASH_STALL_OFF_O,
  // core feature controls
  output logic             CORE_NO_EXT_INSTR_O,
  output logic             CORE_NO_BIT_REVERSE_O,
  output logic             CORE_BASE_SHADOW_ONLY_O,
  output logic             CORE_NO_LONG_BUFFER_O,
  // crossbar arbitration
  output logic             XBAR_ROUND_ROBIN_O,
  // fault capture from core buses
  input  wire logic        FAULT_I,
  input  wire logic [31:0] FAULT_ADDR_I,
  input  wire logic [31:0] FAULT_WDATA_I,
  input  wire logic        FAULT_DATA_I,
  input  wire logic        FAULT_BUFFERABLE_I,
  input  wire logic [1:0]  FAULT_SIZE_I,
  input  wire logic        FAULT_WRITE_I,
  input  wire logic [1:0]  FAULT_LOC_I,
  // interrupt to interrupt controller
  output logic             FAULT_IRQ_O
);

  // compare a bus address against one register offset
  function automatic logic hit_at_off(input logic [11:0] addr, input logic [11:0] off);
    return addr == off;
  endfunction

  // write-one-to-clear flag update; a set in the same cycle wins
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction

  // register state
  logic [6:0]  flash_word;
  logic [3:0]  core_word;
  logic        irq_en;
  logic        st_int;
  logic        st_lost;
  logic [31:0] f_addr;
  logic [31:0] f_data;
  logic [11:0] f_attr;

  // bus decode
  wire         acc      = PSEL_I & PENABLE_I;
  wire         wr       = acc & PWRITE_I & PSTRB_I[0];
  wire         hit_cfg  = hit_at_off(PADDR_I, msc_pkg::OFF_CONFIG);
  wire         hit_fl   = hit_at_off(PADDR_I, msc_pkg::OFF_FLASH);
  wire         hit_co   = hit_at_off(PADDR_I, msc_pkg::OFF_CORE);
  wire         hit_arb  = hit_at_off(PADDR_I, msc_pkg::OFF_ARB);
  wire         hit_fa   = hit_at_off(PADDR_I, msc_pkg::OFF_FADDR);
  wire         hit_at   = hit_at_off(PADDR_I, msc_pkg::OFF_FATTR);
  wire         hit_fd   = hit_at_off(PADDR_I, msc_pkg::OFF_FDATA);
  wire         hit_fc   = hit_at_off(PADDR_I, msc_pkg::OFF_FCTRL);
  wire         hit_fs   = hit_at_off(PADDR_I, msc_pkg::OFF_FSTAT);
  wire         mapped   = hit_cfg | hit_fl | hit_co | hit_arb | hit_fa | hit_at | hit_fd | hit_fc | hit_fs;
  wire         setup    = PSEL_I & ~PENABLE_I;

  // writes act only on the completing access edge, never twice per transfer
  wire         wr_go    = wr & PREADY_O;
  wire         wr_fl    = wr_go & hit_fl;
  wire         wr_co    = wr_go & hit_co;
  wire         wr_arb   = wr_go & hit_arb;
  wire         wr_fc    = wr_go & hit_fc;

  // write-one-to-clear; a new fault in the same cycle wins over the clear
  wire         clr_int  = wr_go & hit_fs & PWDATA_I[msc_pkg::ST_INT_BIT];
  wire         clr_lost = wr_go & hit_fs & PWDATA_I[msc_pkg::ST_LOST_BIT];
  wire         next_st_int  = flag_next(st_int, FAULT_I, clr_int);
  wire         next_st_lost = flag_next(st_lost, FAULT_I & st_int & ~clr_int, clr_lost);

  // fault attribute packing
  wire  [11:0] attr_in;
  assign attr_in[msc_pkg::AT_TYPE_BIT]                       = FAULT_DATA_I;
  assign attr_in[msc_pkg::AT_TYPE_BIT+1]                     = 1'b0;
  assign attr_in[msc_pkg::AT_BUF_BIT]                        = FAULT_BUFFERABLE_I;
  assign attr_in[msc_pkg::AT_BUF_BIT+1]                      = 1'b0;
  assign attr_in[msc_pkg::AT_SIZE_LSB +: 2]                  = FAULT_SIZE_I;
  assign attr_in[msc_pkg::AT_SIZE_LSB+2]                     = 1'b0;
  assign attr_in[msc_pkg::AT_DIR_BIT]                        = FAULT_WRITE_I;
  assign attr_in[msc_pkg::AT_LOC_LSB +: 2]                   = FAULT_LOC_I;
  assign attr_in[msc_pkg::AT_LOC_LSB+2 +: 2]                 = 2'h0;

  // read mux
  // only eight master ports fit the config word
  wire  [31:0] cfg_word = {7'h00, WIDE_PATH, MST_MAP[7:0], SLV_MAP};
  // the clear bit is a strobe and always reads back as zero
  assign flash_word = {FLASH_STALL_OFF_O, FLASH_NO_SPEC_O, FLASH_NO_DATA_SPEC_O, FLASH_CACHE_OFF_O,
                       FLASH_NO_INST_CACHE_O, FLASH_NO_DATA_CACHE_O, 1'b0};
  assign core_word  = {CORE_NO_LONG_BUFFER_O, CORE_BASE_SHADOW_ONLY_O, CORE_NO_BIT_REVERSE_O, CORE_NO_EXT_INSTR_O};
  wire  [31:0] rd_word  =
      hit_cfg ? cfg_word :
      hit_fl  ? {25'h0, flash_word} :
      hit_co  ? {28'h0, core_word} :
      hit_arb ? {31'h0, XBAR_ROUND_ROBIN_O} :
      hit_fa  ? f_addr :
      hit_at  ? {20'h0, f_attr} :
      hit_fd  ? f_data :
      hit_fc  ? {31'h0, irq_en} :
      hit_fs  ? {30'h0, st_lost, st_int} :
                32'h0000_0000;

  // apb answer: one access cycle, error on unmapped address
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      PREADY_O <= 1'b0;
    end else begin
      PREADY_O <= setup;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      PSLVERR_O <= 1'b0;
    end else begin
      PSLVERR_O <= setup & ~mapped;
    end
  end

  // read data is latched in setup so it stands through the access cycle
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PRDATA_O <= (setup & ~PWRITE_I) ? rd_word : 32'h0000_0000;
    end
  end

  // cache clear strobe: high for the one cycle after the write edge
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      FLASH_CACHE_CLEAR_O <= 1'b0;
    end else begin
      FLASH_CACHE_CLEAR_O <= wr_fl & PWDATA_I[msc_pkg::FL_CLEAR_BIT];
    end
  end

  // flash controller controls, each bit its own flop
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      FLASH_NO_DATA_CACHE_O <= msc_pkg::FL_RESET[msc_pkg::FL_NODATA_BIT-1];
    end else if (wr_fl) begin
      FLASH_NO_DATA_CACHE_O <= PWDATA_I[msc_pkg::FL_NODATA_BIT];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      FLASH_NO_INST_CACHE_O <= msc_pkg::FL_RESET[msc_pkg::FL_NOINST_BIT-1];
    end else if (wr_fl) begin
      FLASH_NO_INST_CACHE_O <= PWDATA_I[msc_pkg::FL_NOINST_BIT];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      FLASH_CACHE_OFF_O <= msc_pkg::FL_RESET[msc_pkg::FL_NOCACHE_BIT-1];
    end else if (wr_fl) begin
      FLASH_CACHE_OFF_O <= PWDATA_I[msc_pkg::FL_NOCACHE_BIT];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      FLASH_NO_DATA_SPEC_O <= msc_pkg::FL_RESET[msc_pkg::FL_NODSPEC_BIT-1];
    end else if (wr_fl) begin
      FLASH_NO_DATA_SPEC_O <= PWDATA_I[msc_pkg::FL_NODSPEC_BIT];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      FLASH_NO_SPEC_O <= msc_pkg::FL_RESET[msc_pkg::FL_NOSPEC_BIT-1];
    end else if (wr_fl) begin
      FLASH_NO_SPEC_O <= PWDATA_I[msc_pkg::FL_NOSPEC_BIT];
    end
  end

  // flash controller errors (off) or waits (on) on access during a command
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      FLASH_STALL_OFF_O <= msc_pkg::FL_RESET[msc_pkg::FL_NOSTALL_BIT-1];
    end else if (wr_fl) begin
      FLASH_STALL_OFF_O <= PWDATA_I[msc_pkg::FL_NOSTALL_BIT];
    end
  end

  // core feature controls
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      CORE_NO_EXT_INSTR_O <= msc_pkg::CO_RESET[msc_pkg::CO_NOEXT_BIT];
    end else if (wr_co) begin
      CORE_NO_EXT_INSTR_O <= PWDATA_I[msc_pkg::CO_NOEXT_BIT];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      CORE_NO_BIT_REVERSE_O <= msc_pkg::CO_RESET[msc_pkg::CO_NOREV_BIT];
    end else if (wr_co) begin
      CORE_NO_BIT_REVERSE_O <= PWDATA_I[msc_pkg::CO_NOREV_BIT];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      CORE_BASE_SHADOW_ONLY_O <= msc_pkg::CO_RESET[msc_pkg::CO_NOSHAD_BIT];
    end else if (wr_co) begin
      CORE_BASE_SHADOW_ONLY_O <= PWDATA_I[msc_pkg::CO_NOSHAD_BIT];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      CORE_NO_LONG_BUFFER_O <= msc_pkg::CO_RESET[msc_pkg::CO_NOBUF_BIT];
    end else if (wr_co) begin
      CORE_NO_LONG_BUFFER_O <= PWDATA_I[msc_pkg::CO_NOBUF_BIT];
    end
  end

  // crossbar arbitration: fixed core over dma after reset
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      XBAR_ROUND_ROBIN_O <= msc_pkg::ARB_FIXED_CORE;
    end else if (wr_arb) begin
      XBAR_ROUND_ROBIN_O <= PWDATA_I[msc_pkg::ARB_RR_BIT];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      irq_en <= 1'b0;
    end else if (wr_fc) begin
      irq_en <= PWDATA_I[msc_pkg::FC_IRQ_EN_BIT];
    end
  end

  // fault capture: each fault overwrites the latest record
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      f_addr <= 32'h0000_0000;
    end else if (FAULT_I) begin
      f_addr <= FAULT_ADDR_I;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      f_attr <= 12'h000;
    end else if (FAULT_I) begin
      f_attr <= attr_in;
    end
  end

  // instruction faults and reads carry no write data, so the old word stays
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      f_data <= 32'h0000_0000;
    end else if (FAULT_I & FAULT_WRITE_I & FAULT_DATA_I) begin
      f_data <= FAULT_WDATA_I;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      st_int <= 1'b0;
    end else begin
      st_int <= next_st_int;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      st_lost <= 1'b0;
    end else begin
      st_lost <= next_st_lost;
    end
  end

  // outputs straight from flops
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      FAULT_IRQ_O <= 1'b0;
    end else begin
      FAULT_IRQ_O <= irq_en & FAULT_I;
    end
  end

endmodule // msc_top

/* bench/msc_checker.sv */
// Purpose: port assertions for the misc system control unit
// Assumes: apb writes carry the lane 0 strobe
// Notes:   bound into msc_top
`timescale 1ns/100ps
module msc_checker #(
  parameter logic [15:0] SLV_MAP   = 16'h00ff,
  parameter logic [15:0] MST_MAP   = 16'h000f,
  parameter logic        WIDE_PATH = 1'b0
) (
  // clock, reset, apb
  input wire logic        MCLK_I, RST_N_I, PSEL_I, PENABLE_I, PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O, PSLVERR_O,
  // controls and fault
  input wire logic        FLASH_CACHE_CLEAR_O, FLASH_STALL_OFF_O, XBAR_ROUND_ROBIN_O, FAULT_I, FAULT_IRQ_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  wire acc = PSEL_I & PENABLE_I & PREADY_O;
  wire wr_fl = acc & PWRITE_I & PSTRB_I[0] & (PADDR_I == msc_pkg::OFF_FLASH);
  wire wr_arb = acc & PWRITE_I & PSTRB_I[0] & (PADDR_I == msc_pkg::OFF_ARB);
  wire clr_req = wr_fl & PWDATA_I[0];
  wire rd_cfg = acc & !PWRITE_I & (PADDR_I == msc_pkg::OFF_CONFIG);
  a_clear_cause: assert property (clr_req |=> FLASH_CACHE_CLEAR_O) else $error("clear pulse missing");
  a_clear_single: assert property (FLASH_CACHE_CLEAR_O |=> !FLASH_CACHE_CLEAR_O) else $error("clear too long");
  a_clear_only: assert property (FLASH_CACHE_CLEAR_O |-> $past(clr_req)) else $error("stray clear");
  a_stall_write: assert property (wr_fl |=> FLASH_STALL_OFF_O == $past(PWDATA_I[msc_pkg::FL_NOSTALL_BIT])) else $error("stall bit");
  a_arb_write: assert property (wr_arb |=> XBAR_ROUND_ROBIN_O == $past(PWDATA_I[0])) else $error("arb bit");
  a_ready_time: assert property (PSEL_I & !PENABLE_I |=> PREADY_O) else $error("ready late");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready too long");
  a_err_unmapped: assert property (PSLVERR_O |-> PREADY_O && (PADDR_I[1:0] != 2'h0 || PADDR_I > msc_pkg::OFF_FSTAT)) else $error("bad error");
  a_cfg_read: assert property (rd_cfg |-> PRDATA_O == {7'h0, WIDE_PATH, MST_MAP[7:0], SLV_MAP}) else $error("cfg");
  a_irq_cause: assert property (FAULT_IRQ_O |-> $past(FAULT_I)) else $error("stray irq");
  c_clear: cover property (clr_req);
  c_irq: cover property (FAULT_IRQ_O);
  c_err: cover property (PSLVERR_O);
endmodule // msc_checker
bind msc_top msc_checker #(.SLV_MAP(SLV_MAP), .MST_MAP(MST_MAP), .WIDE_PATH(WIDE_PATH)) u_chk (.*);

/* bench/msc_fault_src.sv */
// Purpose: core bus model that reports one faulted cycle on request
// Assumes: info is {addr, wdata, loc, write, size, buf, data}
// Notes:   info is scrambled outside the pulse, as real buses do not hold it
`timescale 1ns/100ps
module msc_fault_src (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [70:0] req_i,
  output logic             fault_o,
  output logic      [70:0] info_o
);
  always_ff @(posedge clk_i) begin
    fault_o <= go_i;
    info_o  <= go_i ? req_i : ~info_o;
  end
endmodule // msc_fault_src

/* bench/msc_top_bench.sv */
// Purpose: self-checking bench for msc_top
// Assumes: zero wait state apb slave
// Notes:   lfsr stimulus from seed 39
`timescale 1ns/100ps
module msc_top_bench;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, rerr, rr, clr, irq, pready, pslverr, flt;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rdat, prdata, rnd, efd, k;
  logic [70:0] req = 0, info;
  logic [6:0]  ctl;
  logic [5:0]  fl;
  logic [3:0]  co;
  int error_cnt = 0, samples_checked = 0, irq_cnt = 0, clr_cnt = 0, cyc = 0;
  msc_top #(.SLV_MAP(16'h00a5), .MST_MAP(16'h0003), .WIDE_PATH(1'b1)) DUT (.MCLK_I(clk), .RST_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .FLASH_CACHE_CLEAR_O(clr),
    .FLASH_NO_DATA_CACHE_O(fl[0]), .FLASH_NO_INST_CACHE_O(fl[1]), .FLASH_CACHE_OFF_O(fl[2]),
    .FLASH_NO_DATA_SPEC_O(fl[3]), .FLASH_NO_SPEC_O(fl[4]), .FLASH_STALL_OFF_O(fl[5]),
    .CORE_NO_EXT_INSTR_O(co[0]), .CORE_NO_BIT_REVERSE_O(co[1]), .CORE_BASE_SHADOW_ONLY_O(co[2]),
    .CORE_NO_LONG_BUFFER_O(co[3]), .XBAR_ROUND_ROBIN_O(rr), .FAULT_I(flt), .FAULT_ADDR_I(info[70:39]),
    .FAULT_WDATA_I(info[38:7]), .FAULT_LOC_I(info[6:5]), .FAULT_WRITE_I(info[4]), .FAULT_SIZE_I(info[3:2]),
    .FAULT_BUFFERABLE_I(info[1]), .FAULT_DATA_I(info[0]), .FAULT_IRQ_O(irq));
  msc_fault_src u_src (.clk_i(clk), .go_i(go), .req_i(req), .fault_o(flt), .info_o(info));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (clr === 1'b1) clr_cnt <= clr_cnt + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic fault(input logic [31:0] a, input logic [6:0] c);
    @(posedge clk);
    {go, req} <= {1'b1, a, ~a, c};
    @(posedge clk);
    go <= 0;
    repeat (3) @(posedge clk);
  endtask
  task end_sim;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    rnd = 39;
    efd = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    apb(0, msc_pkg::OFF_CONFIG, 0); chk(rdat, 32'h0103_00a5);
    for (int i = 1; i < 9; i++) begin
      apb(0, 12'(4 * i), 0); chk(rdat, 0);
    end
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      apb(1, msc_pkg::OFF_FLASH, rnd & 32'h7e); apb(1, msc_pkg::OFF_CORE, rnd & 32'hf); apb(1, msc_pkg::OFF_ARB, rnd[8]);
      chk({fl, 1'b0}, rnd & 32'h7e);
      chk(co, rnd & 32'hf);
      apb(0, msc_pkg::OFF_FLASH, 0); chk(rdat, rnd & 32'h7e);
      chk(rr, rnd[8]);
    end
    $display("control test done");
    k = clr_cnt;
    apb(1, msc_pkg::OFF_FLASH, 32'h41);
    repeat (3) @(posedge clk);
    chk(clr_cnt - k, 1);
    apb(0, msc_pkg::OFF_FLASH, 0); chk(rdat, 32'h40);
    apb(1, 12'h040, '1); chk(rerr, 1);
    apb(0, 12'h040, 0); chk({rerr, rdat}, {1'b1, 32'h0});
    $display("clear and unmapped test done");
    apb(1, msc_pkg::OFF_FCTRL, 1);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      ctl = {2'(i), rnd[3], 2'(i), rnd[2], rnd[0]};
      k = irq_cnt;
      fault(rnd, ctl);
      if (ctl[0] & ctl[4]) efd = ~rnd;
      chk(irq_cnt - k, 1);
      apb(0, msc_pkg::OFF_FADDR, 0); chk(rdat, rnd);
      apb(0, msc_pkg::OFF_FATTR, 0); chk(rdat, {ctl[6:4], 1'b0, ctl[3:2], 1'b0, ctl[1], 1'b0, ctl[0]});
      apb(0, msc_pkg::OFF_FDATA, 0); chk(rdat, efd);
      apb(0, msc_pkg::OFF_FSTAT, 0); chk(rdat, i == 0 ? 1 : 3);
    end
    apb(1, msc_pkg::OFF_FSTAT, 1); apb(0, msc_pkg::OFF_FSTAT, 0); chk(rdat, 2);
    apb(1, msc_pkg::OFF_FSTAT, 2); apb(0, msc_pkg::OFF_FSTAT, 0); chk(rdat, 0);
    apb(1, msc_pkg::OFF_FCTRL, 0);
    k = irq_cnt;
    fault(rnd, 7'h0);
    chk(irq_cnt - k, 0);
    apb(0, msc_pkg::OFF_FSTAT, 0); chk(rdat, 1);
    $display("fault test done");
    end_sim();
  end
endmodule // msc_top_bench
